// ---- design/l2_cache_pkg.sv ----
package l2_cache_pkg;

    // register map
    localparam logic [7:0] cache_mode_config_addr = 8'h50;
    localparam logic [7:0] scheme_config_addr = 8'h51;
    localparam logic [7:0] region_config_addr = 8'h52;
    localparam logic [7:0] status_addr = 8'h53;
    localparam logic [7:0] cache_mode_config_rst = 8'h00;
    localparam logic [7:0] scheme_config_rst = 8'h00;
    localparam logic [7:0] region_config_rst = 8'h00;

    // cache_mode_config fields
    localparam int mode_lsb = 6;
    localparam int tag_ext_first_bit = 4;
    localparam int tag_ext_second_bit = 5;
    // scheme_config fields
    localparam int writeback_bit = 0;
    localparam int modify_bit_en_bit = 1;
    // region_config fields
    localparam int video_bios_cache_bit = 0;
    localparam int system_bios_cache_bit = 1;
    localparam int dram_size_lsb = 4;

    // geometry: 32-byte lines, tag stored per line
    localparam int addr_w = 32;
    localparam int line_lsb = 5;
    localparam int tag_w = 10;
    localparam logic [31:0] upper_mem_base = 32'h000a0000;
    localparam logic [31:0] upper_mem_top = 32'h00100000;
    localparam logic [31:0] video_bios_lo = 32'h000c0000;
    localparam logic [31:0] video_bios_hi = 32'h000c7fff;
    localparam logic [31:0] system_bios_lo = 32'h000e0000;
    localparam logic [31:0] system_bios_hi = 32'h000effff;
    localparam int region_mult_8 = 256;
    localparam int region_mult_9 = 512;
    localparam int region_mult_10 = 1024;

    typedef enum logic [1:0] {
        mode_enabled = 2'b00,
        mode_init = 2'b01,
        mode_disabled = 2'b10,
        mode_reserved = 2'b11
    } cache_mode_e;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_snoop = 3'b001,
        st_victim_wb = 3'b010,
        st_fill = 3'b011,
        st_respond = 3'b100
    } ctrl_state_e;

    typedef struct packed {
        logic valid;
        logic from_pci;
        logic write;
        logic [31:0] addr;
        logic [3:0] byte_en;
    } cycle_req_s;

endpackage

// ---- design/l2_cache_controller.sv ----
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module l2_cache_controller #(
    parameter int index_w = 13,
    parameter int cache_kb_log2 = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire l2_cache_pkg::cycle_req_s req_in,
    input wire logic snoop_hit_mod_in,
    input wire logic snoop_done_in,
    input wire logic dram_done_in,
    output logic busy_out,
    output logic burst_ready_n_out,
    output logic cacheable_indication_out,
    output logic external_snoop_strobe_out,
    output logic dram_read_out,
    output logic dram_write_out,
    output logic victim_wb_out,
    output logic fwd_from_l1_out,
    output logic cache_data_rd_out,
    output logic [3:0] cache_data_we_out,
    output logic [index_w-1:0] tag_index_out,
    output logic tag_we_out,
    output logic [l2_cache_pkg::tag_w-1:0] tag_wdata_out,
    output logic hit_out,
    output logic next_line_present_out
);

    localparam int lines = 1 << index_w;

    typedef struct packed {
        logic [7:0] mode_cfg;
        logic [7:0] scheme_cfg;
        logic [7:0] region_cfg;
        logic [7:0] rdata;
        l2_cache_pkg::ctrl_state_e state;
        l2_cache_pkg::cycle_req_s cur;
        logic hit;
        logic victim_dirty;
        logic [26:0] last_snoop_line;
        logic last_snoop_valid;
        logic burst_ready_n_n;
        logic cacheable_indication;
        logic external_snoop_strobe;
        logic dram_rd;
        logic dram_wr;
        logic victim_wb;
        logic fwd;
        logic data_rd;
        logic [3:0] data_we;
        logic tag_we;
        logic [l2_cache_pkg::tag_w-1:0] tag_wdata;
        logic next_present;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;
    logic [l2_cache_pkg::tag_w-1:0] tag_ram [lines];
    logic modify_ram [lines];

    function automatic logic [l2_cache_pkg::tag_w-1:0] tag_of(
        input logic [31:0] a
    );
        tag_of = a[l2_cache_pkg::line_lsb+index_w +: l2_cache_pkg::tag_w];
    endfunction

    function automatic logic [index_w-1:0] index_of(input logic [31:0] a);
        index_of = a[l2_cache_pkg::line_lsb +: index_w];
    endfunction

    // active tag width: 8 bits, or 9/10 with the extra tag lines enabled
    logic [3:0] tag_active_w;
    logic [l2_cache_pkg::tag_w-1:0] tag_mask;
    logic [40:0] region_limit;
    logic [40:0] dram_bytes;
    logic in_region;
    logic in_upper;
    logic shadow_ok;
    logic cacheable;
    logic [1:0] mode;
    logic cache_on;
    logic mod_bit_scheme;
    logic [l2_cache_pkg::tag_w-1:0] rd_tag;
    logic rd_mod;
    logic line_invalid;
    logic lookup_hit;
    logic [l2_cache_pkg::tag_w-1:0] next_tag;
    logic [index_w-1:0] next_idx;
    logic [26:0] req_line;

    always_comb begin
        tag_active_w = 4'h8;
        region_limit = 41'(l2_cache_pkg::region_mult_8) << cache_kb_log2 << 10;
        if (cur_ff.mode_cfg[l2_cache_pkg::tag_ext_first_bit]) begin
            tag_active_w = 4'h9;
            region_limit = 41'(l2_cache_pkg::region_mult_9) << cache_kb_log2
                << 10;
        end
        if (cur_ff.mode_cfg[l2_cache_pkg::tag_ext_second_bit]) begin
            tag_active_w = 4'ha;
            region_limit = 41'(l2_cache_pkg::region_mult_10) << cache_kb_log2
                << 10;
        end
        // all active tag lines set means invalid
        tag_mask = l2_cache_pkg::tag_w'((11'h001 << tag_active_w) - 11'h001);
    end

    // dram size field is log2 of megabytes; only local DRAM is cacheable
    assign dram_bytes = 41'h00000100000 <<
        cur_ff.region_cfg[l2_cache_pkg::dram_size_lsb +: 4];
    assign in_region = ({9'h000, req_in.addr} < dram_bytes) &&
        ({9'h000, req_in.addr} < region_limit);
    assign in_upper = req_in.addr >= l2_cache_pkg::upper_mem_base &&
        req_in.addr < l2_cache_pkg::upper_mem_top;
    assign shadow_ok = (cur_ff.region_cfg[l2_cache_pkg::video_bios_cache_bit]
        && req_in.addr >= l2_cache_pkg::video_bios_lo
        && req_in.addr <= l2_cache_pkg::video_bios_hi)
        || (cur_ff.region_cfg[l2_cache_pkg::system_bios_cache_bit]
        && req_in.addr >= l2_cache_pkg::system_bios_lo
        && req_in.addr <= l2_cache_pkg::system_bios_hi);
    assign cacheable = in_region && (!in_upper || shadow_ok);

    assign mode = cur_ff.mode_cfg[l2_cache_pkg::mode_lsb +: 2];
    // only 00 and 01 run the cache; others bypass it
    assign cache_on = mode == 2'b00 || mode == 2'b01;
    assign mod_bit_scheme = cur_ff.scheme_cfg[l2_cache_pkg::modify_bit_en_bit];

    assign rd_tag = tag_ram[index_of(req_in.addr)];
    assign rd_mod = modify_ram[index_of(req_in.addr)];
    assign line_invalid = (rd_tag & tag_mask) == tag_mask;
    assign lookup_hit = !line_invalid &&
        ((rd_tag & tag_mask) == (tag_of(req_in.addr) & tag_mask));
    assign next_idx = index_of(req_in.addr) + index_w'(1);
    assign next_tag = tag_ram[next_idx];
    assign req_line = req_in.addr[31:l2_cache_pkg::line_lsb];

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rdata = 8'h00;
        nxt_cur.burst_ready_n_n = 1'b1;
        nxt_cur.external_snoop_strobe = 1'b0;
        nxt_cur.dram_rd = 1'b0;
        nxt_cur.dram_wr = 1'b0;
        nxt_cur.victim_wb = 1'b0;
        nxt_cur.fwd = 1'b0;
        nxt_cur.data_rd = 1'b0;
        nxt_cur.data_we = 4'h0;
        nxt_cur.tag_we = 1'b0;
        if (reg_wr_in) begin
            case (reg_addr_in)
                l2_cache_pkg::cache_mode_config_addr:
                    nxt_cur.mode_cfg = reg_wdata_in;
                l2_cache_pkg::scheme_config_addr:
                    nxt_cur.scheme_cfg = reg_wdata_in;
                l2_cache_pkg::region_config_addr:
                    nxt_cur.region_cfg = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                l2_cache_pkg::cache_mode_config_addr:
                    nxt_cur.rdata = cur_ff.mode_cfg;
                l2_cache_pkg::scheme_config_addr:
                    nxt_cur.rdata = cur_ff.scheme_cfg;
                l2_cache_pkg::region_config_addr:
                    nxt_cur.rdata = cur_ff.region_cfg;
                l2_cache_pkg::status_addr:
                    nxt_cur.rdata = {4'h0, cur_ff.hit, 3'(cur_ff.state)};
                default: nxt_cur.rdata = 8'h00;
            endcase
        end
        case (cur_ff.state)
            l2_cache_pkg::st_idle: begin
                if (req_in.valid) begin
                    nxt_cur.cur = req_in;
                    nxt_cur.cacheable_indication = cacheable && !req_in.from_pci;
                    // tags hold garbage until init mode has filled them, so
                    // init reads always miss and never write a victim back
                    nxt_cur.hit = cache_on && mode != 2'b01 && cacheable &&
                        lookup_hit;
                    // no modify bit means every victim outside upper memory is dirty
                    nxt_cur.victim_dirty = mode != 2'b01 && cur_ff.scheme_cfg[
                        l2_cache_pkg::writeback_bit] && !line_invalid &&
                        (mod_bit_scheme ? rd_mod : !in_upper);
                    nxt_cur.next_present = (next_tag & tag_mask) ==
                        (tag_of(req_in.addr) & tag_mask);
                    if (req_in.from_pci && cacheable &&
                        !(cur_ff.last_snoop_valid &&
                        cur_ff.last_snoop_line == req_line)) begin
                        nxt_cur.external_snoop_strobe = 1'b1;
                        nxt_cur.last_snoop_line = req_line;
                        nxt_cur.last_snoop_valid = 1'b1;
                        nxt_cur.state = l2_cache_pkg::st_snoop;
                    end else begin
                        nxt_cur.state = l2_cache_pkg::st_respond;
                    end
                end
            end
            l2_cache_pkg::st_snoop: begin
                if (snoop_done_in) begin
                    nxt_cur.fwd = snoop_hit_mod_in && !cur_ff.cur.write;
                    nxt_cur.state = l2_cache_pkg::st_respond;
                end
            end
            l2_cache_pkg::st_victim_wb: begin
                nxt_cur.victim_wb = 1'b1;
                if (dram_done_in) begin
                    nxt_cur.state = l2_cache_pkg::st_fill;
                end
            end
            l2_cache_pkg::st_fill: begin
                nxt_cur.dram_rd = 1'b1;
                if (dram_done_in) begin
                    nxt_cur.data_we = 4'hf;
                    nxt_cur.tag_we = 1'b1;
                    nxt_cur.tag_wdata = tag_of(cur_ff.cur.addr);
                    nxt_cur.burst_ready_n_n = 1'b0;
                    nxt_cur.state = l2_cache_pkg::st_idle;
                end
            end
            l2_cache_pkg::st_respond: begin
                nxt_cur.state = l2_cache_pkg::st_idle;
                if (!cur_ff.cur.write) begin
                    if (cur_ff.hit) begin
                        nxt_cur.data_rd = 1'b1;
                        nxt_cur.burst_ready_n_n = 1'b0;
                        // dirty line drains in the background
                        nxt_cur.victim_wb = cur_ff.victim_dirty;
                    end else if (!cur_ff.cur.from_pci && cache_on &&
                        cur_ff.cacheable_indication) begin
                        nxt_cur.state = cur_ff.victim_dirty ?
                            l2_cache_pkg::st_victim_wb :
                            l2_cache_pkg::st_fill;
                    end else begin
                        nxt_cur.dram_rd = 1'b1;
                        nxt_cur.burst_ready_n_n = 1'b0;
                    end
                end else begin
                    nxt_cur.burst_ready_n_n = 1'b0;
                    if (cur_ff.hit) begin
                        nxt_cur.data_we = cur_ff.cur.byte_en;
                        nxt_cur.dram_wr = !cur_ff.scheme_cfg[
                            l2_cache_pkg::writeback_bit];
                    end else begin
                        nxt_cur.dram_wr = 1'b1;
                    end
                end
            end
            default: nxt_cur.state = l2_cache_pkg::st_idle;
        endcase
        if (!rst_n_in) begin
            nxt_cur = '0;
            nxt_cur.mode_cfg = l2_cache_pkg::cache_mode_config_rst;
            nxt_cur.scheme_cfg = l2_cache_pkg::scheme_config_rst;
            nxt_cur.region_cfg = l2_cache_pkg::region_config_rst;
            nxt_cur.burst_ready_n_n = 1'b1;
            nxt_cur.mode_cfg[l2_cache_pkg::mode_lsb +: 2] = 2'b10;
        end
    end

    always_ff @(posedge clk_in) begin
        cur_ff <= nxt_cur;
        if (cur_ff.tag_we) begin
            tag_ram[tag_index_out] <= cur_ff.tag_wdata;
            modify_ram[tag_index_out] <= 1'b0;
        end else if (cur_ff.data_we != 4'h0 && mod_bit_scheme &&
            cur_ff.scheme_cfg[l2_cache_pkg::writeback_bit]) begin
            modify_ram[tag_index_out] <= 1'b1;
        end
    end

    assign reg_rdata_out = cur_ff.rdata;
    assign busy_out = cur_ff.state != l2_cache_pkg::st_idle;
    assign burst_ready_n_out = cur_ff.burst_ready_n_n;
    assign cacheable_indication_out = cur_ff.cacheable_indication;
    assign external_snoop_strobe_out = cur_ff.external_snoop_strobe;
    assign dram_read_out = cur_ff.dram_rd;
    assign dram_write_out = cur_ff.dram_wr;
    assign victim_wb_out = cur_ff.victim_wb;
    assign fwd_from_l1_out = cur_ff.fwd;
    assign cache_data_rd_out = cur_ff.data_rd;
    assign cache_data_we_out = cur_ff.data_we;
    assign tag_index_out = index_of(cur_ff.cur.addr);
    assign tag_we_out = cur_ff.tag_we;
    assign tag_wdata_out = cur_ff.tag_wdata;
    assign hit_out = cur_ff.hit;
    assign next_line_present_out = cur_ff.next_present;

    AST_WT_HIT_DRAM: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        cur_ff.state == l2_cache_pkg::st_respond && cur_ff.cur.write &&
        cur_ff.hit && !cur_ff.scheme_cfg[0] |=> dram_write_out)
        else $error("writethrough hit did not write dram");
    AST_WMISS_NO_ALLOC: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        cur_ff.state == l2_cache_pkg::st_respond && cur_ff.cur.write &&
        !cur_ff.hit
        |=> !tag_we_out && cache_data_we_out == 4'h0 ##1 !tag_we_out)
        else $error("write miss allocated");
    AST_WMISS_DRAM: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        cur_ff.state == l2_cache_pkg::st_respond && cur_ff.cur.write &&
        !cur_ff.hit |=> dram_write_out && !burst_ready_n_out)
        else $error("write miss not posted to dram with early ready");
    AST_RHIT_READ: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        cur_ff.state == l2_cache_pkg::st_respond && !cur_ff.cur.write &&
        cur_ff.hit |=> cache_data_rd_out && !tag_we_out)
        else $error("read hit not served from cache");
    AST_FILL_TAG: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        cur_ff.state == l2_cache_pkg::st_fill && dram_done_in
        |=> tag_we_out && !burst_ready_n_out && cache_data_we_out == 4'hf)
        else $error("fill did not update tag and return data");
    AST_WB_BEFORE_FILL: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        cur_ff.state == l2_cache_pkg::st_victim_wb && !dram_done_in
        |=> cur_ff.state == l2_cache_pkg::st_victim_wb)
        else $error("victim writeback abandoned");
    AST_SNOOP_FILTER: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        external_snoop_strobe_out |-> cur_ff.last_snoop_valid &&
        $past(req_in.addr[31:5]) == cur_ff.last_snoop_line)
        else $error("snoop line not remembered");
    AST_DISABLED_BYPASS: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !cache_on && cur_ff.state == l2_cache_pkg::st_idle
        |=> !hit_out || !$past(req_in.valid))
        else $error("cache hit reported while disabled");

endmodule

// ---- verification/l2_far_side_model.sv ----
`timescale 1ns/1ps
module l2_far_side_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic snoop_strobe_in,
    input wire logic dram_read_in,
    input wire logic victim_wb_in,
    input wire logic hit_mod_cmd_in,
    input wire logic slow_in,
    output logic snoop_hit_mod_out,
    output logic snoop_done_out,
    output logic dram_done_out
);
    logic [3:0] snp_cnt_ff;
    logic [3:0] dram_cnt_ff;
    logic snp_busy_ff, dram_busy_ff, rd_served_ff, wb_served_ff, toggle_ff;
    // the hit flag means nothing away from the done pulse, so it wanders
    assign snoop_hit_mod_out = snoop_done_out ? hit_mod_cmd_in : toggle_ff;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            {snp_busy_ff, dram_busy_ff, rd_served_ff, wb_served_ff} <= 4'h0;
            {snp_cnt_ff, dram_cnt_ff} <= 8'h00;
            {snoop_done_out, dram_done_out, toggle_ff} <= 3'h0;
        end else begin
            toggle_ff <= ~toggle_ff;
            snoop_done_out <= 1'b0;
            dram_done_out <= 1'b0;
            if (snoop_strobe_in) begin
                snp_busy_ff <= 1'b1;
                snp_cnt_ff <= slow_in ? 4'h6 : 4'h1;
            end else if (snp_busy_ff) begin
                if (snp_cnt_ff == 4'h0) begin
                    snp_busy_ff <= 1'b0;
                    snoop_done_out <= 1'b1;
                end else begin
                    snp_cnt_ff <= snp_cnt_ff - 4'h1;
                end
            end
            // a held request is served once; re-armed only when it drops
            if (!dram_read_in) rd_served_ff <= 1'b0;
            if (!victim_wb_in) wb_served_ff <= 1'b0;
            if (!dram_busy_ff && victim_wb_in && !wb_served_ff) begin
                wb_served_ff <= 1'b1;
                dram_busy_ff <= 1'b1;
                dram_cnt_ff <= slow_in ? 4'h7 : 4'h1;
            end else if (!dram_busy_ff && dram_read_in && !rd_served_ff) begin
                rd_served_ff <= 1'b1;
                dram_busy_ff <= 1'b1;
                dram_cnt_ff <= slow_in ? 4'h5 : 4'h1;
            end else if (dram_busy_ff) begin
                if (dram_cnt_ff == 4'h0) begin
                    dram_busy_ff <= 1'b0;
                    dram_done_out <= 1'b1;
                end else begin
                    dram_cnt_ff <= dram_cnt_ff - 4'h1;
                end
            end
        end
    end
endmodule

// ---- verification/l2_cache_controller_tb_top.sv ----
`timescale 1ns/1ps
module l2_cache_controller_tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    l2_cache_pkg::cycle_req_s req = '0;
    logic busy, burst_ready_n_n, cach, esnp, drd, dwr, vwb, fwd, crd, twe, hit, nlp;
    logic [3:0] we;
    logic [12:0] tidx;
    logic [l2_cache_pkg::tag_w-1:0] twd;
    logic shm, sdone, ddone;
    logic hit_mod = 1'b0, slow = 1'b0, rd_pend = 1'b0;
    logic [11:0] exp_q[$], mask_q[$], seen = 12'h000;
    logic [7:0] rexp_q[$];
    int seed = 80, miscompares = 0, n_tests = 0;
    localparam logic [31:0] line_a = 32'h00001000;
    localparam logic [31:0] line_b = 32'h00041000;

    l2_cache_controller #(.index_w(13), .cache_kb_log2(8)) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .req_in(req), .snoop_hit_mod_in(shm),
        .snoop_done_in(sdone), .dram_done_in(ddone), .busy_out(busy),
        .burst_ready_n_out(burst_ready_n_n), .cacheable_indication_out(cach),
        .external_snoop_strobe_out(esnp), .dram_read_out(drd),
        .dram_write_out(dwr), .victim_wb_out(vwb), .fwd_from_l1_out(fwd),
        .cache_data_rd_out(crd), .cache_data_we_out(we),
        .tag_index_out(tidx), .tag_we_out(twe), .tag_wdata_out(twd),
        .hit_out(hit), .next_line_present_out(nlp));

    l2_far_side_model u_far (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .snoop_strobe_in(esnp),
        .dram_read_in(drd), .victim_wb_in(vwb), .hit_mod_cmd_in(hit_mod),
        .slow_in(slow), .snoop_hit_mod_out(shm), .snoop_done_out(sdone),
        .dram_done_out(ddone));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // bits: hit cacheable dram_rd dram_wr victim snoop fwd tag_we we[3:0]
    always @(posedge clk_in) begin
        logic [11:0] obs, e, m;
        if (rd_pend) begin
            n_tests++;
            e[7:0] = rexp_q.pop_front();
            if (reg_rdata !== e[7:0]) begin
                $display("[FAIL] %0t register read %h expected %h", $time,
                    reg_rdata, e[7:0]);
                miscompares++;
            end
        end
        rd_pend = reg_rd;
        obs = {hit, cach, seen[9:0] | {drd, dwr, vwb, esnp, fwd, twe, we}};
        if (rst_n_in && !burst_ready_n_n && exp_q.size() > 0) begin
            n_tests++;
            e = exp_q.pop_front();
            m = mask_q.pop_front();
            if ((obs & m) !== (e & m)) begin
                $display("[FAIL] %0t cycle result %h expected %h mask %h",
                    $time, obs, e, m);
                miscompares++;
            end
            seen = 12'h000;
        end else begin
            seen = rst_n_in ? obs : 12'h000;
        end
    end

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        rexp_q.push_back(e);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(posedge clk_in);
    endtask

    // in a write, an expected byte-enable field of all ones stands for the random enables
    task automatic access(input logic pci, input logic wr,
        input logic [31:0] a, input logic [11:0] e, input logic [11:0] m);
        int n;
        logic [3:0] be;
        logic [4:0] off;
        be = 4'($random(seed));
        be[0] = 1'b1;
        off = 5'($random(seed));
        if (wr && e[3:0] == 4'hf) e[3:0] = be;
        exp_q.push_back(e);
        mask_q.push_back(m);
        @(posedge clk_in);
        req <= '{1'b1, pci, wr, {a[31:5], off[4:2], 2'b00}, be};
        n = 0;
        @(posedge clk_in);
        while (busy && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        req.valid <= 1'b0;
        while (burst_ready_n_n && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 400) begin
            $display("[FAIL] %0t no burst ready for %h", $time, a);
            miscompares++;
        end
        @(posedge clk_in);
    endtask

    initial begin
        #300000;
        miscompares++;
        $display("[FAIL] %0t run did not finish", $time);
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        reg_read(8'h50, 8'h80);
        reg_read(8'h7f, 8'h00);
        access(1'b0, 1'b1, line_a, 12'h100, 12'h11f);
        access(1'b0, 1'b0, line_a, 12'h200, 12'h21f);
        reg_write(8'h52, 8'h40);
        reg_write(8'h51, 8'h03);
        reg_read(8'h51, 8'h03);
        reg_write(8'h50, 8'h40);
        access(1'b0, 1'b0, line_a, 12'h210, 12'ha50);
        reg_write(8'h50, 8'h00);
        reg_read(8'h50, 8'h00);
        access(1'b0, 1'b0, line_a, 12'hc00, 12'hfdf);
        access(1'b0, 1'b1, line_a, 12'h80f, 12'h90f);
        slow <= 1'b1;
        access(1'b0, 1'b0, line_b, 12'h290, 12'hb90);
        access(1'b0, 1'b0, line_b, 12'hc00, 12'hfdf);
        access(1'b0, 1'b1, line_a, 12'h100, 12'h91f);
        reg_write(8'h51, 8'h00);
        access(1'b0, 1'b1, line_b, 12'h90f, 12'h90f);
        access(1'b1, 1'b0, line_b, 12'h840, 12'hc5f);
        access(1'b1, 1'b0, line_b, 12'h800, 12'h85f);
        hit_mod <= 1'b1;
        access(1'b1, 1'b0, line_a, 12'h260, 12'ha7f);
        hit_mod <= 1'b0;
        access(1'b1, 1'b1, line_b, 12'h84f, 12'h84f);
        access(1'b0, 1'b0, 32'h000a0000, 12'h000, 12'h410);
        reg_write(8'h50, 8'hc0);
        reg_read(8'h50, 8'hc0);
        access(1'b0, 1'b1, line_b, 12'h100, 12'h11f);
        repeat (3) @(posedge clk_in);
        close_out();
    end
endmodule
